// [shared/ifpa_params.svh]
// Register offsets, field positions, reset values and timing counts for the flag/priority block.
`ifndef IFPA_PARAMS_SVH
`define IFPA_PARAMS_SVH
`define IFPA_OFF_FLAGS 12'h000
`define IFPA_OFF_PRIO 12'h004
`define IFPA_OFF_IRQ_STAT 12'h008
`define IFPA_OFF_IRQ_MASK 12'h00C
`define IFPA_OFF_CTRL 12'h010
`define IFPA_OFF_PIPE 12'h014
`define IFPA_BIT_CCP4 0
`define IFPA_BIT_CLC4 1
`define IFPA_FLAGS_MASK 8'h03
`define IFPA_PRIO_MASK 8'hEF
`define IFPA_PRIO_RESET 8'hEF
`define IFPA_NOOP_CYCLES 1
`define IFPA_BIT_GLOBAL_EN 0
`define IFPA_BIT_SRC_EN_CCP4 1
`define IFPA_BIT_SRC_EN_CLC4 2
`define IFPA_IST_VECTOR 0
`define IFPA_IST_ABORT 1
`define IFPA_IST_FLAG 2
`endif

// [shared/ifpa_pkg.sv]
// Types shared by the flag/priority/abort block.
package ifpa_pkg;
  typedef enum logic [2:0] {
    IFPA_RUN = 3'b001,
    IFPA_ARMED = 3'b010,
    IFPA_NOOP = 3'b100
  } ifpa_state_t;
  typedef struct packed {
    logic clc4;
    logic ccp4;
  } ifpa_events_t;
  typedef struct packed {
    logic vector_req;
    logic forced_noop_cycle;
    logic resume;
  } ifpa_seq_t;
endpackage

// [hw/ifpa_ctrl.sv]
// APB-reached flag and priority registers with the aborted-interrupt sequencer.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ifpa_params.svh"
module ifpa_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ifpa_pkg::ifpa_events_t src_event,
  input wire logic instr_cycle,
  input wire logic last_before_vector,
  output ifpa_pkg::ifpa_seq_t seq_out,
  output logic [7:0] high_priority_pending,
  output logic irq
);
  import ifpa_pkg::*;

  logic [7:0] flags_reg;
  logic [7:0] prio_reg;
  logic [2:0] ctrl_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  ifpa_state_t state_reg;
  ifpa_seq_t seq_reg;
  logic request;
  logic wr_en;
  logic rd_en;
  logic [7:0] evt_bits;
  logic [7:0] flags_next;
  logic abort_evt;
  logic vector_evt;
  logic flags_wr;
  logic prio_wr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign evt_bits = {6'h00, src_event.clc4, src_event.ccp4};
  // Register write decodes shared by the checks below.
  assign flags_wr = wr_en && hit(paddr, `IFPA_OFF_FLAGS);
  assign prio_wr = wr_en && hit(paddr, `IFPA_OFF_PRIO);

  // Pending request: flag, its source enable and the global enable all set.
  assign request = ctrl_reg[`IFPA_BIT_GLOBAL_EN] &&
    ((flags_reg[`IFPA_BIT_CCP4] && ctrl_reg[`IFPA_BIT_SRC_EN_CCP4]) ||
     (flags_reg[`IFPA_BIT_CLC4] && ctrl_reg[`IFPA_BIT_SRC_EN_CLC4]));

  // Unmapped addresses answer with an error so a stray access is visible.
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(hit(paddr, `IFPA_OFF_FLAGS) || hit(paddr, `IFPA_OFF_PRIO) ||
        hit(paddr, `IFPA_OFF_IRQ_STAT) || hit(paddr, `IFPA_OFF_IRQ_MASK) ||
        hit(paddr, `IFPA_OFF_CTRL) || hit(paddr, `IFPA_OFF_PIPE));
    end
  end

  // Writes may only clear flags; set events win over a clearing write.
  always_comb begin
    flags_next = flags_reg;
    if (wr_en && hit(paddr, `IFPA_OFF_FLAGS)) begin
      flags_next = flags_reg & pwdata[7:0];
    end
    flags_next = (flags_next | evt_bits) & `IFPA_FLAGS_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // The hole at bit 4 is masked on write, so it can never read back as one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_reg <= `IFPA_PRIO_RESET;
    end else if (wr_en && hit(paddr, `IFPA_OFF_PRIO)) begin
      prio_reg <= pwdata[7:0] & `IFPA_PRIO_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 3'h0;
    end else if (wr_en && hit(paddr, `IFPA_OFF_CTRL)) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  // Sequencer: ARMED means the request was seen and vectoring follows the
  // instruction flagged as last. Losing the request then costs one noop.
  assign abort_evt = (state_reg == IFPA_ARMED) && instr_cycle && last_before_vector &&
    !request;
  assign vector_evt = (state_reg == IFPA_ARMED) && instr_cycle && last_before_vector &&
    request;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IFPA_RUN;
      seq_reg <= '0;
    end else begin
      seq_reg <= '0;
      case (state_reg)
        IFPA_RUN: begin
          if (instr_cycle && request) begin
            state_reg <= IFPA_ARMED;
          end
        end
        IFPA_ARMED: begin
          if (instr_cycle) begin
            if (last_before_vector) begin
              if (request) begin
                seq_reg.vector_req <= 1'b1;
                state_reg <= IFPA_RUN;
              end else begin
                seq_reg.forced_noop_cycle <= 1'b1;
                state_reg <= IFPA_NOOP;
              end
            end else if (!request) begin
              state_reg <= IFPA_RUN;
            end
          end
        end
        IFPA_NOOP: begin
          if (instr_cycle) begin
            seq_reg.resume <= 1'b1;
            state_reg <= IFPA_RUN;
          end else begin
            seq_reg.forced_noop_cycle <= 1'b1;
          end
        end
        default: begin
          state_reg <= IFPA_RUN;
        end
      endcase
    end
  end

  assign seq_out = seq_reg;

  // A registered view keeps the pending output free of decode glitches, at one cycle of lag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_priority_pending <= 8'h00;
    end else begin
      high_priority_pending <= prio_reg & {6'h00, flags_reg[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_en && hit(paddr, `IFPA_OFF_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // Interrupt status: write one to clear, a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
        ~((wr_en && hit(paddr, `IFPA_OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0)) |
        {|evt_bits, abort_evt, vector_evt};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (1'b1)
        hit(paddr, `IFPA_OFF_FLAGS): prdata = {24'h00_0000, flags_reg};
        hit(paddr, `IFPA_OFF_PRIO): prdata = {24'h00_0000, prio_reg};
        hit(paddr, `IFPA_OFF_IRQ_STAT): prdata = {29'h0000_0000, irq_stat_reg};
        hit(paddr, `IFPA_OFF_IRQ_MASK): prdata = {29'h0000_0000, irq_mask_reg};
        hit(paddr, `IFPA_OFF_CTRL): prdata = {29'h0000_0000, ctrl_reg};
        hit(paddr, `IFPA_OFF_PIPE): prdata = {29'h0000_0000, state_reg};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  chk_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    src_event.ccp4 |=> flags_reg[0]) else $error("ccp4 event did not set flag");
  chk_clc_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    src_event.clc4 |=> flags_reg[1]) else $error("clc4 event did not set flag");
  chk_flag_no_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[0] && !(wr_en && hit(paddr, `IFPA_OFF_FLAGS)) |=> flags_reg[0])
    else $error("flag cleared without software write");
  chk_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `IFPA_OFF_FLAGS) && !pwdata[0] && src_event.ccp4 |=> flags_reg[0])
    else $error("set lost against clear");
  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    flags_reg[7:2] == 6'h00 && prio_reg[4] == 1'b0) else $error("unused bit not zero");
  chk_prio_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `IFPA_OFF_PRIO) |=> prio_reg == ($past(pwdata[7:0]) & 8'hEF))
    else $error("priority write not stored");
  chk_abort_one_noop: assert property (@(posedge pclk) disable iff (!presetn)
    abort_evt |=> seq_out.forced_noop_cycle && !seq_out.vector_req)
    else $error("abort did not give forced noop");
  chk_noop_then_resume: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IFPA_NOOP && instr_cycle |=> seq_out.resume && state_reg == IFPA_RUN)
    else $error("forced noop did not resume");
  chk_early_no_noop: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IFPA_ARMED && instr_cycle && !last_before_vector && !request
    |=> state_reg == IFPA_RUN && !seq_out.forced_noop_cycle)
    else $error("early withdrawal added a cycle");
  // The per-flag checks are alike for both implemented bits, so one loop makes them.
  for (genvar gi = 0; gi < 2; gi++) begin : g_flag_chk
    chk_flag_set_each: assert property (@(posedge pclk) disable iff (!presetn)
      evt_bits[gi] |=> flags_reg[gi])
      else $error("event did not set its flag");
    chk_flag_hold_each: assert property (@(posedge pclk) disable iff (!presetn)
      flags_reg[gi] && !(flags_wr && !pwdata[gi]) |=> flags_reg[gi])
      else $error("flag dropped without a clearing write");
    chk_flag_clear_each: assert property (@(posedge pclk) disable iff (!presetn)
      flags_wr && !pwdata[gi] && !evt_bits[gi] |=> !flags_reg[gi])
      else $error("clearing write did not clear flag");
    chk_flag_no_spurious: assert property (@(posedge pclk) disable iff (!presetn)
      !flags_reg[gi] |=> !flags_reg[gi] || $past(evt_bits[gi]))
      else $error("flag set without an event");
  end
  chk_flag_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit(paddr, `IFPA_OFF_FLAGS) |-> prdata[31:2] == 30'h0000_0000 &&
    prdata[1:0] == flags_reg[1:0])
    else $error("flag read shows wrong bits");
  chk_prio_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit(paddr, `IFPA_OFF_PRIO) |-> prdata[31:8] == 24'h00_0000 && !prdata[4])
    else $error("priority read shows unused bits");
  chk_prio_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !prio_wr |=> $stable(prio_reg))
    else $error("priority changed without a write");
  chk_pending_view: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> high_priority_pending == $past(prio_reg & {6'h00, flags_reg[1:0]}))
    else $error("pending view wrong");
  chk_seq_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(seq_out))
    else $error("sequencer pulses overlap");
  chk_state_legal: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(state_reg))
    else $error("sequencer state not one-hot");
  chk_noop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IFPA_NOOP && !instr_cycle |=> seq_out.forced_noop_cycle &&
    !seq_out.resume && state_reg == IFPA_NOOP)
    else $error("forced noop left early");
  chk_vector_no_noop: assert property (@(posedge pclk) disable iff (!presetn)
    vector_evt |=> seq_out.vector_req && !seq_out.forced_noop_cycle)
    else $error("vector pulse wrong");
  chk_run_no_noop: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == IFPA_RUN |=> !seq_out.forced_noop_cycle)
    else $error("noop outside abort");
  chk_stat_flag_event: assert property (@(posedge pclk) disable iff (!presetn)
    |evt_bits |=> irq_stat_reg[`IFPA_IST_FLAG])
    else $error("event status bit not set");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == |$past(irq_stat_reg & irq_mask_reg))
    else $error("interrupt level wrong");
  cov_abort: cover property (@(posedge pclk) disable iff (!presetn) abort_evt);
  cov_noop_resume: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == IFPA_NOOP && instr_cycle);
  cov_vector: cover property (@(posedge pclk) disable iff (!presetn) vector_evt);
  cov_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `IFPA_OFF_FLAGS) && src_event.ccp4);
endmodule

// [sim/ifpa_core_model.sv]
// Behavioural model of the instruction pipeline and the peripheral event sources.
`timescale 1ns/1ps
module ifpa_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic last_req,
  input wire logic [1:0] fire,
  output ifpa_pkg::ifpa_events_t src_event,
  output logic instr_cycle,
  output logic last_before_vector
);
  import ifpa_pkg::*;
  // Instruction boundaries come only on request, so the bench sets the pace of the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_event <= '0;
      instr_cycle <= 1'b0;
      last_before_vector <= 1'b0;
    end else begin
      src_event <= fire;
      instr_cycle <= step;
      last_before_vector <= step & last_req;
    end
  end
endmodule

// [sim/tb_interrupt_flag_priority_abort.sv]
// Self-checking bench for the flag, priority and aborted-interrupt block.
`timescale 1ns/1ps
`include "ifpa_params.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_interrupt_flag_priority_abort;
  import ifpa_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, step = 0, last_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] fire = '0;
  logic pready, pslverr, err, irq, instr_cycle, last_before_vector;
  logic [7:0] high_priority_pending;
  ifpa_events_t src_event;
  ifpa_seq_t seq_out;
  int fail_count = 0, check_count = 0, n_vec = 0, n_noop = 0, n_res = 0;
  ifpa_core_model core (.pclk(pclk), .presetn(presetn), .step(step), .last_req(last_req),
    .fire(fire), .src_event(src_event), .instr_cycle(instr_cycle),
    .last_before_vector(last_before_vector));
  ifpa_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .instr_cycle(instr_cycle),
    .last_before_vector(last_before_vector), .seq_out(seq_out),
    .high_priority_pending(high_priority_pending), .irq(irq));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (seq_out.vector_req === 1'b1) n_vec++;
    if (seq_out.forced_noop_cycle === 1'b1) n_noop++;
    if (seq_out.resume === 1'b1) n_res++;
  end
  task close_out;
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task fire_ev(input logic [1:0] f);
    @(posedge pclk) fire <= f;
    @(posedge pclk) fire <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask
  task instr(input logic l);
    @(posedge pclk) step <= 1;
    last_req <= l;
    @(posedge pclk) step <= 0;
    last_req <= 0;
    repeat (4) @(posedge pclk);
  endtask
  // Leaves one capture event pending and enabled, with the sequencer armed.
  task arm;
    apb(1'b1, `IFPA_OFF_FLAGS, 32'h0);
    fire_ev(2'h1);
    apb(1'b1, `IFPA_OFF_CTRL, 32'h3);
    instr(1'b0);
    rd_chk(`IFPA_OFF_PIPE, 32'h2);
    n_vec = 0;
    n_noop = 0;
    n_res = 0;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rd_chk(`IFPA_OFF_FLAGS, 32'h0);
    rd_chk(`IFPA_OFF_PRIO, 32'hEF);
    apb(1'b1, `IFPA_OFF_PRIO, 32'hFF);
    rd_chk(`IFPA_OFF_PRIO, 32'hEF);
    apb(1'b1, `IFPA_OFF_PRIO, 32'h0);
    rd_chk(`IFPA_OFF_PRIO, 32'h0);
    fire_ev(2'h3);
    rd_chk(`IFPA_OFF_FLAGS, 32'h3);
    `CHK(high_priority_pending, 8'h00)
    apb(1'b1, `IFPA_OFF_PRIO, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(high_priority_pending, 8'h03)
    apb(1'b1, `IFPA_OFF_FLAGS, 32'hFD);
    rd_chk(`IFPA_OFF_FLAGS, 32'h1);
    apb(1'b1, `IFPA_OFF_FLAGS, 32'h0);
    rd_chk(`IFPA_OFF_FLAGS, 32'h0);
    // The event lands on the very edge that takes the clearing write.
    fork
      apb(1'b1, `IFPA_OFF_FLAGS, 32'h0);
      begin
        @(posedge pclk) fire <= 2'h1;
        @(posedge pclk) fire <= 2'h0;
      end
    join
    rd_chk(`IFPA_OFF_FLAGS, 32'h1);
    arm();
    apb(1'b1, `IFPA_OFF_FLAGS, 32'h0);
    instr(1'b1);
    instr(1'b0);
    `CHK(n_vec, 0)
    `CHK(n_noop != 0, 1'b1)
    `CHK(n_res, 1)
    rd_chk(`IFPA_OFF_PIPE, 32'h1);
    arm();
    apb(1'b1, `IFPA_OFF_FLAGS, 32'h0);
    instr(1'b0);
    `CHK(n_noop + n_vec, 0)
    rd_chk(`IFPA_OFF_PIPE, 32'h1);
    arm();
    instr(1'b1);
    `CHK(n_vec, 1)
    `CHK(n_noop, 0)
    apb(1'b1, `IFPA_OFF_CTRL, 32'h0);
    apb(1'b1, `IFPA_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `IFPA_OFF_IRQ_MASK, 32'h4);
    fire_ev(2'h2);
    `CHK(irq, 1'b1)
    apb(1'b1, `IFPA_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, `IFPA_OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `IFPA_OFF_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h020, 32'hFF);
    `CHK(err, 1'b1)
    close_out();
  end
endmodule
